// [hw/gpio_port_register_file.v]
// Eight-pin general purpose port register file with AHB-Lite slave
`timescale 1ns/1ps
`include "gpio_port_regs.vh"

// Notes on behaviour
// - Direction bit 1 drives pin, 0 releases
// - Direction never touches the input buffer
// - Direction set alias ORs ones in
// - Direction clear alias clears where ones
// - Direction flip alias inverts where ones
// - Direction aliases read back direction register
// - Output level matters only when driver enabled
// - Level 0 drives low, 1 drives high
// - Level set alias ORs ones in
// - Level clear alias clears where ones
// - Flip alias or input write inverts level
// - Level aliases read back output level
// - Zero bits written to aliases do nothing
// - Input bit tracks pin while buffer on
// - Input bit 0 low, 1 high
// - Flag set on configured pin condition
// - Writing one clears a flag
// - Sense 4 kills buffer, 0 buffer only
module gpio_port_register_file (
    input  wire        SYS_CLK,
    input  wire        RESET_N,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    input  wire [7:0]  PIN_IN,
    output reg  [7:0]  PIN_OUT,
    output reg  [7:0]  PIN_OE,
    output reg  [7:0]  PIN_BUF_EN
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg  [7:0] dir_q;
    reg  [7:0] dir_d;
    reg  [7:0] out_q;
    reg  [7:0] out_d;
    wire [7:0] in_q;
    wire [7:0] in_d;
    wire [7:0] flag_q;
    wire [7:0] flag_d;
    reg  [2:0] sense_q [0:7];
    reg  [2:0] sense_d [0:7];
    reg  [7:0] sync1_q;
    reg  [7:0] sync2_q;
    reg  [7:0] buf_en_d;
    reg  [7:0] flag_clr;
    reg        wr_q;
    reg  [5:0] widx_q;
    reg [31:0] rdata_d;
    wire       addr_phase;
    wire [5:0] hidx;
    wire [7:0] wbyte;
    integer    i;
    integer    j;
    integer    k;

    assign addr_phase = HSEL & HTRANS[`HTRANS_ACTIVE_BIT] & HREADY;
    assign hidx       = HADDR[`IDX_MSB:`IDX_LSB];
    assign wbyte      = HWDATA[7:0];

    // ----------------------------------------------------------------
    // Bus address phase capture
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_q   <= 1'b0;
            widx_q <= `RST_IDX;
        end else begin
            wr_q   <= addr_phase & HWRITE;
            widx_q <= hidx;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_q <= `RST_BYTE;
            sync2_q <= `RST_BYTE;
        end else begin
            sync1_q <= PIN_IN;
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // Next-state of direction, level and sense config
    // ----------------------------------------------------------------
    always @* begin
        dir_d    = dir_q;
        out_d    = out_q;
        flag_clr = `RST_BYTE;
        for (i = 0; i < 8; i = i + 1) begin
            sense_d[i] = sense_q[i];
        end
        if (wr_q) begin
            case (widx_q)
                `IDX_PIN_DIRECTION: begin
                    dir_d = wbyte;
                end
                `IDX_PIN_WAY_SET_ALIAS: begin
                    dir_d = dir_q | wbyte;
                end
                `IDX_PIN_WAY_CLEAR_ALIAS: begin
                    dir_d = dir_q & ~wbyte;
                end
                `IDX_PIN_WAY_FLIP_ALIAS: begin
                    dir_d = dir_q ^ wbyte;
                end
                `IDX_OUTPUT_LEVEL: begin
                    out_d = wbyte;
                end
                `IDX_DRIVE_LEVEL_SET: begin
                    out_d = out_q | wbyte;
                end
                `IDX_DRIVE_LEVEL_CLEAR: begin
                    out_d = out_q & ~wbyte;
                end
                `IDX_DRIVE_LEVEL_FLIP, `IDX_INPUT_VALUE: begin
                    // Input value itself is never written
                    out_d = out_q ^ wbyte;
                end
                `IDX_PIN_EVENT_FLAGS: begin
                    flag_clr = wbyte;
                end
                default: begin
                    for (i = 0; i < 8; i = i + 1) begin
                        if (widx_q[5:3] == `IDX_SENSE_GROUP && widx_q[2:0] == i[2:0]) begin
                            sense_d[i] = wbyte[2:0];
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Input buffer enables
    // ----------------------------------------------------------------
    // Buffer enable depends on sense config alone, never on direction
    always @* begin
        buf_en_d = `RST_BYTE;
        for (j = 0; j < 8; j = j + 1) begin
            buf_en_d[j] = (sense_d[j] != `SENSE_INPUT_DISABLE);
        end
    end

    // ----------------------------------------------------------------
    // Per-pin input sampling and event flags
    // ----------------------------------------------------------------
    // Edges compare against the held input value, so a pin that moved
    // while its buffer was off can raise a flag on re-enable.
    pin_sense_cell u_pin_sense_cell_0 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[0]),
        .sense  (sense_q[0]),
        .clear  (flag_clr[0]),
        .in_d   (in_d[0]),
        .flag_d (flag_d[0]),
        .in_q   (in_q[0]),
        .flag_q (flag_q[0])
    );
    pin_sense_cell u_pin_sense_cell_1 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[1]),
        .sense  (sense_q[1]),
        .clear  (flag_clr[1]),
        .in_d   (in_d[1]),
        .flag_d (flag_d[1]),
        .in_q   (in_q[1]),
        .flag_q (flag_q[1])
    );
    pin_sense_cell u_pin_sense_cell_2 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[2]),
        .sense  (sense_q[2]),
        .clear  (flag_clr[2]),
        .in_d   (in_d[2]),
        .flag_d (flag_d[2]),
        .in_q   (in_q[2]),
        .flag_q (flag_q[2])
    );
    pin_sense_cell u_pin_sense_cell_3 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[3]),
        .sense  (sense_q[3]),
        .clear  (flag_clr[3]),
        .in_d   (in_d[3]),
        .flag_d (flag_d[3]),
        .in_q   (in_q[3]),
        .flag_q (flag_q[3])
    );
    pin_sense_cell u_pin_sense_cell_4 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[4]),
        .sense  (sense_q[4]),
        .clear  (flag_clr[4]),
        .in_d   (in_d[4]),
        .flag_d (flag_d[4]),
        .in_q   (in_q[4]),
        .flag_q (flag_q[4])
    );
    pin_sense_cell u_pin_sense_cell_5 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[5]),
        .sense  (sense_q[5]),
        .clear  (flag_clr[5]),
        .in_d   (in_d[5]),
        .flag_d (flag_d[5]),
        .in_q   (in_q[5]),
        .flag_q (flag_q[5])
    );
    pin_sense_cell u_pin_sense_cell_6 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[6]),
        .sense  (sense_q[6]),
        .clear  (flag_clr[6]),
        .in_d   (in_d[6]),
        .flag_d (flag_d[6]),
        .in_q   (in_q[6]),
        .flag_q (flag_q[6])
    );
    pin_sense_cell u_pin_sense_cell_7 (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .level  (sync2_q[7]),
        .sense  (sense_q[7]),
        .clear  (flag_clr[7]),
        .in_d   (in_d[7]),
        .flag_d (flag_d[7]),
        .in_q   (in_q[7]),
        .flag_q (flag_q[7])
    );

    // ----------------------------------------------------------------
    // Register update
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dir_q      <= `RST_BYTE;
            out_q      <= `RST_BYTE;
            PIN_OUT    <= `RST_BYTE;
            PIN_OE     <= `RST_BYTE;
            PIN_BUF_EN <= `RST_BUF_EN;
            for (k = 0; k < 8; k = k + 1) begin
                sense_q[k] <= `RST_SENSE;
            end
        end else begin
            dir_q      <= dir_d;
            out_q      <= out_d;
            PIN_OE     <= dir_d;
            // Pin level resolves outside from the enable
            PIN_OUT    <= out_d;
            PIN_BUF_EN <= buf_en_d;
            for (k = 0; k < 8; k = k + 1) begin
                sense_q[k] <= sense_d[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data comes from next-state values so a read right after a
    // write sees it, with no wait state.
    always @* begin
        rdata_d = `RST_WORD;
        case (hidx)
            `IDX_PIN_DIRECTION, `IDX_PIN_WAY_SET_ALIAS,
            `IDX_PIN_WAY_CLEAR_ALIAS, `IDX_PIN_WAY_FLIP_ALIAS: begin
                rdata_d = {`DATA_PAD, dir_d};
            end
            `IDX_OUTPUT_LEVEL, `IDX_DRIVE_LEVEL_SET,
            `IDX_DRIVE_LEVEL_CLEAR, `IDX_DRIVE_LEVEL_FLIP: begin
                rdata_d = {`DATA_PAD, out_d};
            end
            `IDX_INPUT_VALUE: begin
                rdata_d = {`DATA_PAD, in_d};
            end
            `IDX_PIN_EVENT_FLAGS: begin
                rdata_d = {`DATA_PAD, flag_d};
            end
            default: begin
                if (hidx[5:3] == `IDX_SENSE_GROUP) begin
                    rdata_d = {`SENSE_PAD, sense_d[hidx[2:0]]};
                end
            end
        endcase
    end

    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            HRDATA    <= `RST_WORD;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            if (addr_phase && !HWRITE) begin
                HRDATA <= rdata_d;
            end
        end
    end

endmodule

// ----------------------------------------------------------------
// One pin: held input, condition match and sticky event flag
// ----------------------------------------------------------------
module pin_sense_cell (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       level,
    input  wire [2:0] sense,
    input  wire       clear,
    output reg        in_d,
    output reg        flag_d,
    output reg        in_q,
    output reg        flag_q
);

    reg match;

    always @* begin
        in_d  = in_q;
        match = `RST_BIT;
        if (sense != `SENSE_INPUT_DISABLE) begin
            in_d = level;
            case (sense)
                `SENSE_BOTH_EDGES: begin
                    match = level ^ in_q;
                end
                `SENSE_RISING: begin
                    match = level & ~in_q;
                end
                `SENSE_FALLING: begin
                    match = ~level & in_q;
                end
                `SENSE_LOW_LEVEL: begin
                    match = ~level;
                end
                default: begin
                    // Off setting and reserved codes never flag
                    match = `RST_BIT;
                end
            endcase
        end
        // A new event wins over a clear in the same cycle
        flag_d = (flag_q & ~clear) | match;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_q   <= `RST_BIT;
            flag_q <= `RST_BIT;
        end else begin
            in_q   <= in_d;
            flag_q <= flag_d;
        end
    end

endmodule

// [hw/gpio_port_regs.vh]
// Register indices, field values and reset values of the eight-pin port
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PIN_DIRECTION        6'h00
`define IDX_PIN_WAY_SET_ALIAS    6'h01
`define IDX_PIN_WAY_CLEAR_ALIAS  6'h02
`define IDX_PIN_WAY_FLIP_ALIAS   6'h03
`define IDX_OUTPUT_LEVEL         6'h04
`define IDX_DRIVE_LEVEL_SET      6'h05
`define IDX_DRIVE_LEVEL_CLEAR    6'h06
`define IDX_DRIVE_LEVEL_FLIP     6'h07
`define IDX_INPUT_VALUE          6'h08
`define IDX_PIN_EVENT_FLAGS      6'h09
// Per-pin sense config occupies indices 0x10..0x17
`define IDX_SENSE_GROUP          3'h2

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
`define IDX_MSB                  7
`define IDX_LSB                  2
`define HTRANS_ACTIVE_BIT        1

// ----------------------------------------------------------------
// Sense configuration values
// ----------------------------------------------------------------
`define SENSE_OFF_SETTING        3'h0
`define SENSE_BOTH_EDGES         3'h1
`define SENSE_RISING             3'h2
`define SENSE_FALLING            3'h3
`define SENSE_INPUT_DISABLE      3'h4
`define SENSE_LOW_LEVEL          3'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE                 8'h00
`define RST_SENSE                3'h0
`define RST_BIT                  1'b0
`define RST_BUF_EN               8'hFF
`define RST_IDX                  6'h00
`define RST_WORD                 32'h0000_0000
`define DATA_PAD                 24'h00_0000
`define SENSE_PAD                29'h0000_0000

`endif

// [testbench/pin_board.sv]
// Board-side model of the eight port pins
`timescale 1ns/1ps
module pin_board (
    input  wire logic [7:0] PIN_OUT,
    input  wire logic [7:0] PIN_OE,
    input  wire logic [7:0] board_lvl,
    output logic      [7:0] PIN_IN
);
    // Driven pins show the port level, released pins the board level
    assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & board_lvl);
endmodule

// [testbench/gpio_port_register_file_properties.sv]
// Concurrent checks of the port register file at its ports
`timescale 1ns/1ps
module gpio_port_register_file_chk (
    input wire logic        SYS_CLK,
    input wire logic        RESET_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [2:0]  HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [7:0]  PIN_IN,
    input wire logic [7:0]  PIN_OUT,
    input wire logic [7:0]  PIN_OE,
    input wire logic [7:0]  PIN_BUF_EN
);
    logic       wr_q;
    logic       rd_q;
    logic [5:0] ix_q;
    wire  [7:0] d = HWDATA[7:0];
    // ------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ix_q <= 6'h00;
        end else if (HREADY) begin
            wr_q <= HSEL & HTRANS[1] & HWRITE;
            rd_q <= HSEL & HTRANS[1] & ~HWRITE;
            ix_q <= HADDR[7:2];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    a_dir_write: assert property (wr_q && ix_q == 0 |=> PIN_OE == $past(d))
        else $error("direction write not on driver enables");
    a_dir_set: assert property (wr_q && ix_q == 1 |=> PIN_OE == ($past(PIN_OE) | $past(d)))
        else $error("direction set alias wrong");
    a_dir_clear: assert property (wr_q && ix_q == 2 |=> PIN_OE == ($past(PIN_OE) & ~$past(d)))
        else $error("direction clear alias wrong");
    a_dir_flip: assert property (wr_q && ix_q == 3 |=> PIN_OE == ($past(PIN_OE) ^ $past(d)))
        else $error("direction flip alias wrong");
    a_dir_readback: assert property (rd_q && ix_q >= 1 && ix_q <= 3 |-> HRDATA[7:0] == PIN_OE)
        else $error("direction alias read wrong");
    a_level_write: assert property (wr_q && ix_q == 4 |=> PIN_OUT == $past(d))
        else $error("level write not on pin levels");
    a_level_set: assert property (wr_q && ix_q == 5 |=> PIN_OUT == ($past(PIN_OUT) | $past(d)))
        else $error("level set alias wrong");
    a_level_clear: assert property (wr_q && ix_q == 6 |=> PIN_OUT == ($past(PIN_OUT) & ~$past(d)))
        else $error("level clear alias wrong");
    a_level_flip: assert property (wr_q && (ix_q == 7 || ix_q == 8) |=> PIN_OUT == ($past(PIN_OUT) ^ $past(d)))
        else $error("level flip wrong");
    a_level_readback: assert property (rd_q && ix_q >= 5 && ix_q <= 7 |-> HRDATA[7:0] == PIN_OUT)
        else $error("level alias read wrong");
    a_buffer_sense: assert property (wr_q && ix_q[5:3] == 3'h2 |=> PIN_BUF_EN[$past(ix_q[2:0])] == ($past(d[2:0]) != 3'h4))
        else $error("input buffer enable wrong");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready and okay");
    cover property (wr_q && ix_q == 7);
    cover property (rd_q && ix_q == 2);
    cover property (wr_q && ix_q == 6'h10 && d[2:0] == 3'h4);
endmodule
bind gpio_port_register_file gpio_port_register_file_chk u_gpio_port_register_file_chk (
    .SYS_CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA,
    .HREADYOUT, .HRESP, .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_BUF_EN);

// [testbench/gpio_port_register_file_test.sv]
// Self-checking bench of the eight-pin port register file
`timescale 1ns/1ps
module gpio_port_register_file_test;
    logic        SYS_CLK, RESET_N, HSEL, HWRITE;
    logic [31:0] HADDR, HWDATA, rd;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    wire  [31:0] HRDATA;
    wire         HREADYOUT, HRESP;
    wire  [7:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_BUF_EN;
    logic [7:0]  board_lvl;
    logic [15:0] seed, st;
    logic [5:0]  ix;
    int          bad_count, compares, cyc;
    gpio_port_register_file u_gpio_port_register_file (.SYS_CLK, .RESET_N, .HSEL, .HADDR,
        .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
        .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_BUF_EN);
    pin_board u_pin_board (.PIN_OUT, .PIN_OE, .board_lvl, .PIN_IN);
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic [15:0] lfsr(input [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Direction in the upper byte, level in the lower
    function automatic [15:0] nxt(input [5:0] i, input [7:0] d, input [15:0] s);
        case (i)
            6'h00: s[15:8] = d;
            6'h01: s[15:8] = s[15:8] | d;
            6'h02: s[15:8] = s[15:8] & ~d;
            6'h03: s[15:8] = s[15:8] ^ d;
            6'h04: s[7:0] = d;
            6'h05: s[7:0] = s[7:0] | d;
            6'h06: s[7:0] = s[7:0] & ~d;
            6'h07, 6'h08: s[7:0] = s[7:0] ^ d;
            default: ;
        endcase
        return s;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic xfer(input logic wr, input logic [5:0] i, input logic [7:0] d);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h00_0000, i, 2'b00};
        HWRITE <= wr;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= {24'h00_0000, d};
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        rd = HRDATA;
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Cut a hang short well past the expected run length
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        {RESET_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA, board_lvl} = '0;
        HSIZE = 3'h2;
        seed = 16'hE1E0;
        st = 16'h0000;
        repeat (16) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            xfer(1'b0, k[5:0], 8'h00);
            chk("reset value", 8'h00, rd[7:0]);
        end
        chk("buffer reset", 8'hFF, PIN_BUF_EN);
        repeat (40) begin
            seed = lfsr(seed);
            board_lvl <= seed[15:8];
            ix = 6'(seed[3:0] % 11);
            xfer(1'b1, ix, seed[7:0]);
            st = nxt(ix, seed[7:0], st);
            #1 chk("direction", st[15:8], PIN_OE);
            chk("level", st[7:0], PIN_OUT);
            xfer(1'b0, {4'h0, seed[5:4]}, 8'h00);
            chk("direction alias", st[15:8], rd[7:0]);
            xfer(1'b0, {4'h1, seed[5:4]}, 8'h00);
            chk("level alias", st[7:0], rd[7:0]);
            repeat (4) @(posedge SYS_CLK);
            xfer(1'b0, 6'h08, 8'h00);
            chk("input", (st[15:8] & st[7:0]) | (~st[15:8] & seed[15:8]), rd[7:0]);
        end
        xfer(1'b1, 6'h02, 8'h01);
        for (int c = 0; c < 6; c++) begin
            xfer(1'b1, 6'h10, c[7:0]);
            board_lvl[0] <= 1'b0;
            #1 chk("buffer", (c == 4) ? 8'hFE : 8'hFF, PIN_BUF_EN);
            repeat (4) @(posedge SYS_CLK);
            xfer(1'b1, 6'h09, 8'hFF);
            board_lvl[0] <= 1'b1;
            repeat (4) @(posedge SYS_CLK);
            xfer(1'b1, 6'h09, 8'h00);
            xfer(1'b0, 6'h09, 8'h00);
            chk("flag rise", {7'h00, c == 1 || c == 2 || c == 5}, rd[7:0]);
            xfer(1'b0, 6'h08, 8'h00);
            chk("held input", {7'h00, c != 4}, {7'h00, rd[0]});
            xfer(1'b1, 6'h09, 8'h01);
            board_lvl[0] <= 1'b0;
            repeat (4) @(posedge SYS_CLK);
            xfer(1'b0, 6'h09, 8'h00);
            chk("flag fall", {7'h00, c == 1 || c == 3 || c == 5}, rd[7:0]);
        end
        conclude();
    end
endmodule
